// File: shared/dtc_pkg.sv
// constants and types shared by the dual timer/counter block
package dtc_pkg;

	// register port geometry
	localparam int ADDR_W = 3;                  // register address width
	localparam int DATA_W = 8;                  // register data width
	localparam int NUM_UNITS = 2;               // timer/counter units

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_MODE = 3'h0;    // timer_mode_register
	localparam logic [ADDR_W-1:0] OFF_RUN = 3'h1;     // run control
	localparam logic [ADDR_W-1:0] OFF_CNT0_LO = 3'h2; // unit 0 low byte
	localparam logic [ADDR_W-1:0] OFF_CNT0_HI = 3'h3; // unit 0 high byte
	localparam logic [ADDR_W-1:0] OFF_CNT1_LO = 3'h4; // unit 1 low byte
	localparam logic [ADDR_W-1:0] OFF_CNT1_HI = 3'h5; // unit 1 high byte

	// field layout of one unit's nibble in timer_mode_register
	localparam int CFG_W = 4;                   // bits per unit
	localparam int RUN_W = 2;                   // run bits in use

	// operating modes from mode_select_high / mode_select_low
	localparam logic [1:0] MODE_PRESCALED = 2'h0; // 8 bit, divide by 32
	localparam logic [1:0] MODE_FULL16 = 2'h1;    // 16 bit
	localparam logic [1:0] MODE_AUTORELOAD = 2'h2; // 8 bit with reload
	localparam logic [1:0] MODE_SPLIT = 2'h3;     // split / stop

	// reset values
	localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
	localparam logic [RUN_W-1:0] RUN_RST = 2'h0;
	localparam logic [DATA_W-1:0] CNT_RST = 8'h00;
	localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

	// timing: one machine cycle is this many oscillator periods
	localparam int MC_DIV = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

	// prescaler width in the prescaled mode (divide by 32)
	localparam int PRE_W = 5;
	localparam logic [PRE_W-1:0] PRE_MAX = 5'h1f;
	localparam logic [DATA_W-1:0] BYTE_MAX = 8'hff;

	// one unit's configuration nibble
	typedef struct packed {
		logic       gate_en;  // count only while gate input high
		logic       cnt_src;  // 1: external events, 0: machine cycles
		logic [1:0] mode;     // {mode_select_high, mode_select_low}
	} dtc_unit_cfg_t;

	// one register access from software
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} dtc_reg_req_t;

endpackage : dtc_pkg

// File: rtl/dtc_timer.sv
// two timer/counter units with four modes, event and gate inputs
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps

module dtc_timer
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              arst_n_i,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] rd_data_o,
	// board pins
	input  wire logic              event_input_zero_i,
	input  wire logic              event_input_one_i,
	input  wire logic              gate_input_zero_i,
	input  wire logic              gate_input_one_i
);

	dtc_reg_req_t             req;                    // bundled request
	logic [DATA_W-1:0]        timer_mode_register_reg; // both nibbles
	logic [RUN_W-1:0]         run_reg;                // run bit per unit
	logic [3:0]               mc_cnt_reg;             // oscillator divider
	logic                     mc_en_reg;              // machine cycle pulse
	logic [NUM_UNITS-1:0]     evt_pin;                // event pins
	logic [NUM_UNITS-1:0]     gate_pin;               // gate pins
	logic [NUM_UNITS-1:0]     inc;                    // count pulse per unit
	logic [NUM_UNITS-1:0]     fall;                   // detected event edge
	logic [NUM_UNITS-1:0]     gate_ok;                // gate allows counting
	dtc_unit_cfg_t            cfg [NUM_UNITS];        // decoded config

	// bundle the software request
	assign req.addr = reg_addr_i;
	assign req.wdata = reg_wdata_i;
	assign req.wr = reg_wr_i;
	assign req.rd = reg_rd_i;
	assign evt_pin = {event_input_one_i, event_input_zero_i};
	assign gate_pin = {gate_input_one_i, gate_input_zero_i};

	// machine cycle enable: one pulse per twelve oscillator periods
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mc_cnt_reg <= 4'h0;
			mc_en_reg <= 1'b0;
		end else if (mc_cnt_reg == MC_LAST) begin
			mc_cnt_reg <= 4'h0;
			mc_en_reg <= 1'b1;
		end else begin
			mc_cnt_reg <= mc_cnt_reg + 4'h1;
			mc_en_reg <= 1'b0;
		end
	end

	// mode register: software picks mode, source and gating per unit
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_mode_register_reg <= MODE_RST;
		end else if (req.wr && req.addr == OFF_MODE) begin
			timer_mode_register_reg <= req.wdata;
		end
	end

	// run bits start and stop each unit
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_reg <= RUN_RST;
		end else if (req.wr && req.addr == OFF_RUN) begin
			run_reg <= req.wdata[RUN_W-1:0];
		end
	end

	// per unit: pin capture, edge detect and the count itself
	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
		logic [1:0]        evt_sync_reg;  // event synchroniser
		logic [1:0]        gate_sync_reg; // gate synchroniser
		logic              evt_smp_reg;   // event level at last cycle
		logic [DATA_W-1:0] lo_reg;        // low count byte
		logic [DATA_W-1:0] hi_reg;        // high count byte / reload
		logic              wr_lo;         // software writes low byte
		logic              wr_hi;         // software writes high byte
		logic              hi_own_inc;    // split high byte count pulse

		assign cfg[u] = dtc_unit_cfg_t'(
			timer_mode_register_reg[u*CFG_W +: CFG_W]);
		assign wr_lo = req.wr && req.addr == OFF_CNT0_LO + 3'(2*u);
		assign wr_hi = req.wr && req.addr == OFF_CNT0_HI + 3'(2*u);

		// two flip-flops before any logic looks at a pin
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				evt_sync_reg <= 2'h0;
				gate_sync_reg <= 2'h0;
			end else begin
				evt_sync_reg <= {evt_sync_reg[0], evt_pin[u]};
				gate_sync_reg <= {gate_sync_reg[0], gate_pin[u]};
			end
		end

		// sample the event level once each machine cycle
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				evt_smp_reg <= 1'b0;
			end else if (mc_en_reg) begin
				evt_smp_reg <= evt_sync_reg[1];
			end
		end

		// high in one machine cycle, low in the next: an edge
		assign fall[u] = mc_en_reg && evt_smp_reg
			&& !evt_sync_reg[1];
		// gating passes counts only while the gate pin is high
		assign gate_ok[u] = !cfg[u].gate_en || gate_sync_reg[1];
		// count pulse from machine cycles or from event edges
		assign inc[u] = run_reg[u] && gate_ok[u]
			&& (cfg[u].cnt_src ? fall[u] : mc_en_reg);
		// in split mode unit 0's high byte is a plain timer on run bit 1
		assign hi_own_inc = (u == 0) && cfg[u].mode == MODE_SPLIT
			&& mc_en_reg && run_reg[1];

		// low byte; software writes win over counting
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				lo_reg <= CNT_RST;
			end else if (wr_lo) begin
				lo_reg <= req.wdata;
			end else if (inc[u]) begin
				case (cfg[u].mode)
					MODE_PRESCALED: begin
						// only the five prescaler bits move
						lo_reg[PRE_W-1:0] <= lo_reg[PRE_W-1:0]
							+ 5'h1;
					end
					MODE_FULL16: begin
						lo_reg <= lo_reg + 8'h1;
					end
					MODE_AUTORELOAD: begin
						// overflow reloads from the high byte
						if (lo_reg == BYTE_MAX) begin
							lo_reg <= hi_reg;
						end else begin
							lo_reg <= lo_reg + 8'h1;
						end
					end
					default: begin
						// split: unit 0 keeps counting, unit 1 halts
						if (u == 0) begin
							lo_reg <= lo_reg + 8'h1;
						end
					end
				endcase
			end
		end

		// high byte
		always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				hi_reg <= CNT_RST;
			end else if (wr_hi) begin
				hi_reg <= req.wdata;
			end else if (hi_own_inc) begin
				hi_reg <= hi_reg + 8'h1;
			end else if (inc[u]) begin
				case (cfg[u].mode)
					MODE_PRESCALED: begin
						// carry out of the divide-by-32 prescaler
						if (lo_reg[PRE_W-1:0] == PRE_MAX) begin
							hi_reg <= hi_reg + 8'h1;
						end
					end
					MODE_FULL16: begin
						if (lo_reg == BYTE_MAX) begin
							hi_reg <= hi_reg + 8'h1;
						end
					end
					default: begin
						// reload value or split high byte: untouched
						hi_reg <= hi_reg;
					end
				endcase
			end
		end
	end

	// read data, valid only in the cycle after the read strobe
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= RD_IDLE;
		end else if (req.rd) begin
			case (req.addr)
				OFF_MODE:    rd_data_o <= timer_mode_register_reg;
				OFF_RUN:     rd_data_o <= DATA_W'(run_reg);
				OFF_CNT0_LO: rd_data_o <= g_unit[0].lo_reg;
				OFF_CNT0_HI: rd_data_o <= g_unit[0].hi_reg;
				OFF_CNT1_LO: rd_data_o <= g_unit[1].lo_reg;
				OFF_CNT1_HI: rd_data_o <= g_unit[1].hi_reg;
				default:     rd_data_o <= RD_IDLE;
			endcase
		end else begin
			rd_data_o <= RD_IDLE;
		end
	end

	// checks on the counting behaviour and on the read port
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	// no software write touches the unit 0 counter
	logic no_wr0;
	assign no_wr0 = !(req.wr && (req.addr == OFF_CNT0_LO
		|| req.addr == OFF_CNT0_HI));

	// a machine cycle pulse, eleven quiet clocks, then the next pulse
	sequence mc_tick_s;
		mc_en_reg;
	endsequence
	sequence mc_quiet_s;
		!mc_en_reg [*8];
	endsequence
	sequence mc_rest_s;
		!mc_en_reg [*3];
	endsequence

	// the enable divides the oscillator by exactly twelve
	mc_period_a: assert property (
		mc_tick_s |-> ##1 mc_quiet_s ##1 mc_rest_s ##1 mc_tick_s)
		else $error("machine cycle pulse not every twelve clocks");

	// mode 1: both bytes step together as one sixteen bit count
	full_count_a: assert property (
		inc[0] && cfg[0].mode == MODE_FULL16 && no_wr0 |=>
		{g_unit[0].hi_reg, g_unit[0].lo_reg}
		== $past({g_unit[0].hi_reg, g_unit[0].lo_reg}) + 16'h1)
		else $error("16-bit mode did not add one");

	// mode 0: a prescaler wrap carries into the high byte
	prescale_carry_a: assert property (
		inc[0] && cfg[0].mode == MODE_PRESCALED && no_wr0
		&& g_unit[0].lo_reg[PRE_W-1:0] == PRE_MAX |=>
		g_unit[0].hi_reg == $past(g_unit[0].hi_reg) + 8'h1
		&& g_unit[0].lo_reg[PRE_W-1:0] == 5'h0)
		else $error("prescaler carry lost");

	// mode 0: the high byte rests while the prescaler runs
	prescale_hold_a: assert property (
		inc[0] && cfg[0].mode == MODE_PRESCALED && no_wr0
		&& g_unit[0].lo_reg[PRE_W-1:0] != PRE_MAX |=>
		$stable(g_unit[0].hi_reg))
		else $error("high byte moved before prescaler wrapped");

	// mode 2: overflow loads the low byte from the reload byte
	reload_load_a: assert property (
		inc[0] && cfg[0].mode == MODE_AUTORELOAD && no_wr0
		&& g_unit[0].lo_reg == BYTE_MAX |=>
		g_unit[0].lo_reg == $past(g_unit[0].hi_reg))
		else $error("auto reload did not load the reload byte");

	// mode 3: unit 1 holds its count
	unit1_stop_a: assert property (
		cfg[1].mode == MODE_SPLIT && !req.wr |=>
		$stable({g_unit[1].hi_reg, g_unit[1].lo_reg}))
		else $error("unit 1 counted in split mode");

	// mode 3: unit 0 high byte times machine cycles on run bit 1
	split_high_a: assert property (
		cfg[0].mode == MODE_SPLIT && run_reg[1] && mc_en_reg && no_wr0
		|=> g_unit[0].hi_reg == $past(g_unit[0].hi_reg) + 8'h1)
		else $error("split high byte did not count");

	// counter function: a seen falling edge adds one to unit 1
	event_edge_a: assert property (
		run_reg[1] && cfg[1].cnt_src && !cfg[1].gate_en
		&& cfg[1].mode == MODE_FULL16 && fall[1] && !req.wr
		|=> g_unit[1].lo_reg == $past(g_unit[1].lo_reg) + 8'h1)
		else $error("event edge not counted");

	// an edge needs a high sample one machine cycle before the low one
	sequence evt_was_high_s;
		$past(g_unit[1].evt_sync_reg[1], 12);
	endsequence

	two_cycle_a: assert property (
		fall[1] |-> evt_was_high_s ##12 !fall[1])
		else $error("edge taken without two machine cycle samples");

	// a closed gate freezes the unit 0 low byte
	gate_block_a: assert property (
		cfg[0].gate_en && !g_unit[0].gate_sync_reg[1] && no_wr0
		|=> $stable(g_unit[0].lo_reg))
		else $error("count passed a closed gate");

	// read data stand one cycle, then fall back to the idle value
	rd_idle_a: assert property (
		!req.rd |=> rd_data_o == RD_IDLE)
		else $error("read data stood longer than one cycle");

	// a read of the mode register returns its contents
	rd_mode_a: assert property (
		req.rd && req.addr == OFF_MODE
		|=> rd_data_o == $past(timer_mode_register_reg))
		else $error("mode register read back wrong");

endmodule : dtc_timer

// File: testbench/dtc_pin_model.sv
// board-side model of the event pin and the two gate pins
`timescale 1ns/1ps
module dtc_pin_model #(
	parameter int HALF = 24  // clocks per level, keeps rate below clk/24
) (
	// clock
	input  wire logic       ref_clk_i,
	// commands from the bench
	input  wire logic       go_i,
	input  wire logic [7:0] num_i,
	input  wire logic [1:0] gate_i,
	// board pins
	output logic            evt_o,
	output logic [1:0]      gate_o,
	output logic            busy_o
);
	int left = 0;  // level changes still to make
	int cnt  = 0;  // clocks left in this level

	// gate levels follow the bench
	assign gate_o = gate_i;
	assign busy_o = (left != 0);

	// event line idles high like a pulled-up port pin
	initial evt_o = 1'b1;

	// each level stands HALF clocks, two machine cycles at least
	always @(posedge ref_clk_i) begin
		if (go_i) begin
			left <= 2 * int'(num_i);
			cnt  <= HALF;
		end else if (left != 0) begin
			if (cnt == 1) begin
				evt_o <= ~evt_o;
				cnt   <= HALF;
				left  <= left - 1;
			end else begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : dtc_pin_model

// File: testbench/test_dual_timer_counter.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module test_dual_timer_counter;
	import dtc_pkg::*;
	logic              ref_clk = 1'b0;  // 10 MHz oscillator
	logic              arst_n  = 1'b0;  // reset, active low
	logic [ADDR_W-1:0] addr    = '0;    // register address
	logic [DATA_W-1:0] wdata   = '0;    // write data
	logic              wr      = 1'b0;  // write strobe
	logic              rd      = 1'b0;  // read strobe
	logic [DATA_W-1:0] rdata;           // read data
	logic              go      = 1'b0;  // start a pulse train
	logic [7:0]        num     = 8'h00; // pulses in the train
	logic [1:0]        gate    = 2'h0;  // wanted gate levels
	logic [1:0]        gate_pin;        // gate pins
	logic              evt;             // event pin of both units
	logic              busy;            // train in progress
	logic [DATA_W-1:0] d;               // last read value
	int                mismatches = 0;
	int                cmp_count  = 0;

	// clock generator
	always #50 ref_clk = ~ref_clk;

	dtc_timer dtc_timer_i (
		.ref_clk_i         (ref_clk),
		.arst_n_i          (arst_n),
		.reg_addr_i        (addr),
		.reg_wdata_i       (wdata),
		.reg_wr_i          (wr),
		.reg_rd_i          (rd),
		.rd_data_o         (rdata),
		.event_input_zero_i(evt),
		.event_input_one_i (evt),
		.gate_input_zero_i (gate_pin[0]),
		.gate_input_one_i  (gate_pin[1])
	);

	dtc_pin_model dtc_pin_model_i (
		.ref_clk_i(ref_clk),
		.go_i     (go),
		.num_i    (num),
		.gate_i   (gate),
		.evt_o    (evt),
		.gate_o   (gate_pin),
		.busy_o   (busy)
	);

	// verdict and end of run
	task complete_run;
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// one write cycle
	task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// one read cycle, data taken in the cycle after the strobe
	task rd_reg(input logic [ADDR_W-1:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// read a register and check it lies in lo..hi
	task chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] lo,
		input logic [DATA_W-1:0] hi);
		rd_reg(a);
		cmp_count++;
		if ((d >= lo && d <= hi) !== 1'b1) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h..%h", $time, d, lo, hi);
		end
	endtask : chk

	// wait whole machine cycles
	task mc(input int n);
		repeat (MC_DIV * n) @(posedge ref_clk);
	endtask : mc

	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		// reset values, unmapped places read zero
		for (int a = 0; a < 8; a++)
			chk(3'(a), 8'h00, 8'h00);
		// 16-bit timer, carry into the high byte
		wr_reg(OFF_MODE, 8'h01);
		wr_reg(OFF_CNT0_LO, 8'hf0);
		wr_reg(OFF_RUN, 8'h01);
		mc(32);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT0_HI, 8'h01, 8'h01);
		chk(OFF_CNT0_LO, 8'h10, 8'h11);
		// prescaled mode, high byte steps when the prescaler wraps from 1f to 00
		wr_reg(OFF_MODE, 8'h00);
		wr_reg(OFF_CNT0_LO, 8'h1e);
		wr_reg(OFF_CNT0_HI, 8'h05);
		wr_reg(OFF_RUN, 8'h01);
		mc(4);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT0_HI, 8'h06, 8'h06);
		chk(OFF_CNT0_LO, 8'h02, 8'h03);
		// auto reload from the high byte
		wr_reg(OFF_MODE, 8'h02);
		wr_reg(OFF_CNT0_HI, 8'hf0);
		wr_reg(OFF_CNT0_LO, 8'hfe);
		wr_reg(OFF_RUN, 8'h01);
		mc(5);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT0_LO, 8'hf3, 8'hf4);
		chk(OFF_CNT0_HI, 8'hf0, 8'hf0);
		// split unit 0, unit 1 held
		wr_reg(OFF_MODE, 8'h33);
		for (int a = 2; a < 6; a++)
			wr_reg(3'(a), 8'h00);
		wr_reg(OFF_RUN, 8'h03);
		mc(10);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT0_LO, 8'h0a, 8'h0b);
		chk(OFF_CNT0_HI, 8'h0a, 8'h0b);
		chk(OFF_CNT1_LO, 8'h00, 8'h00);
		chk(OFF_CNT1_HI, 8'h00, 8'h00);
		// unit 1 counts falling edges of its event pin
		wr_reg(OFF_MODE, 8'h50);
		wr_reg(OFF_RUN, 8'h02);
		@(posedge ref_clk);
		num <= 8'h05;
		go  <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		#1;
		for (int i = 0; busy === 1'b1; i++) begin
			if (i == 1000) begin
				mismatches++;
				complete_run();
			end
			@(posedge ref_clk);
			#1;
		end
		mc(3);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT1_LO, 8'h05, 8'h05);
		// gated timer: no count while the gate pin is low
		wr_reg(OFF_MODE, 8'h09);
		wr_reg(OFF_CNT0_LO, 8'h00);
		wr_reg(OFF_CNT0_HI, 8'h00);
		wr_reg(OFF_RUN, 8'h01);
		mc(10);
		chk(OFF_CNT0_LO, 8'h00, 8'h00);
		// open the gate on a clock edge
		@(posedge ref_clk);
		gate <= 2'h1;
		mc(10);
		wr_reg(OFF_RUN, 8'h00);
		chk(OFF_CNT0_LO, 8'h09, 8'h0b);
		complete_run();
	end
endmodule : test_dual_timer_counter
